// ---- hdl/general_timer_module.sv ----
// dual 16-bit timer block with AXI4-Lite registers, pins and interrupt
// assumes one clock aclk; pins are asynchronous and are filtered here
//
// Summary of operation
// - two 16-bit halves, each a timer or an external event counter
// - halves join into one 32-bit timer or one 32-bit real-time clock
// - joined 32-bit runs as real-time clock, one-shot or periodic timer
// - split halves run one-shot or periodic, with optional 8-bit prescaler
// - a split half can capture input events or generate pwm
// - timer events can trigger an ADC conversion
// - pwm waveform on the pin has a software inversion option
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
`include "timer_cfg.svh"
module general_timer_module (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire timer_pkg::addr_t s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    input  wire timer_pkg::word_t s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire timer_pkg::addr_t s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    output var  timer_pkg::word_t s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [1:0]       ccp_in,
    output var  logic [1:0]       ccp_out,
    output var  logic [1:0]       ccp_oe,
    input  wire logic             rtc_in,
    output var  logic             adc_trigger,
    output var  logic             irq
);
    import timer_pkg::*;

    logic [`CTL_W-1:0] ctl   [2];
    half_t             load  [2];
    half_t             match [2];
    logic [7:0]        pre   [2];
    logic [1:0]        cfg;
    logic [3:0]        status;
    logic [3:0]        irq_en;
    logic [3:0]        ev_set;
    logic [2:0]        s1, s2, s3, filt, filt_d;
    logic [2:0]        edge_p;
    logic [2:0]        pin_raw;
    addr_t             aw_addr;
    word_t             w_data;
    logic [3:0]        w_strb;
    logic              aw_got, w_got, do_wr;
    logic [1:0]        reload;
    logic              concat;

    half_if hb[2] ();

    function automatic logic known(input addr_t a);
        known = a <= `TMR_ICLR_OFF && a[1:0] == 2'b00;
    endfunction

    function automatic word_t merge(input word_t old, input word_t d, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    assign concat  = cfg[`CFG_CONCAT_BIT];
    assign pin_raw = {rtc_in, ccp_in};
    assign do_wr  = aw_got && w_got && !s_axi_bvalid;

    // pin filters: three flops, change taken when stages two and three agree
    generate
        for (genvar p = 0; p < 3; p++) begin : g_pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1[p]     <= 1'b0;
                    s2[p]     <= 1'b0;
                    s3[p]     <= 1'b0;
                    filt[p]   <= 1'b0;
                    filt_d[p] <= 1'b0;
                end else begin
                    s1[p]     <= pin_raw[p];
                    s2[p]     <= s1[p];
                    s3[p]     <= s2[p];
                    filt[p]   <= (s2[p] == s3[p]) ? s3[p] : filt[p];
                    filt_d[p] <= filt[p];
                end
            end
            assign edge_p[p] = filt[p] && !filt_d[p];
        end
    endgenerate

    // halves; in 32-bit mode half 0 is the low word, half 1 the high word
    generate
        for (genvar i = 0; i < 2; i++) begin : g_half
            logic [`CTL_W-1:0] c;
            assign c = concat ? ctl[0] : ctl[i];
            assign hb[i].en       = c[`CTL_EN_BIT] && !(concat && i == 0 && hb[1].done);
            assign hb[i].mode     = concat ? ((cfg[`CFG_RTC_BIT] || c[`CTL_MODE_LSB+1] || c[`CTL_MODE_LSB]
                                               || (i == 0 && hb[1].count != 16'h0000))
                                              ? MODE_PERIODIC : MODE_ONESHOT)
                                           : mode_e'(c[`CTL_MODE_LSB +: 2]);
            assign hb[i].evt_sel  = c[`CTL_EVT_BIT] && !concat;
            assign hb[i].invert   = c[`CTL_INV_BIT];
            assign hb[i].chain    = concat;
            assign hb[i].use_tick = concat && (i == 1 || cfg[`CFG_RTC_BIT]);
            assign hb[i].tick_in  = (i == 1) ? hb[0].timeout : edge_p[2];
            assign hb[i].ev       = edge_p[i];
            assign hb[i].reload   = reload[i];
            assign hb[i].load     = load[i];
            assign hb[i].match    = match[i];
            assign hb[i].pre      = pre[i];
            assign ev_set[2*i+`STAT_TO_BIT]  = concat ? (i == 1 && hb[1].timeout) : hb[i].timeout;
            assign ev_set[2*i+`STAT_CAP_BIT] = hb[i].cap_evt;
            timer_half u_half (
                .aclk    (aclk),
                .aresetn (aresetn),
                .h       (hb[i])
            );
        end
    endgenerate

    // write channel handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_got        <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_got        <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg    <= 2'b00;
            irq_en <= 4'h0;
            reload <= 2'b11;
            for (int i = 0; i < 2; i++) begin
                ctl[i]   <= `CTL_RST;
                load[i]  <= `LOAD_RST;
                match[i] <= `MATCH_RST;
                pre[i]   <= `PRE_RST;
            end
        end else begin
            reload <= 2'b00;
            if (do_wr) begin
                if (aw_addr == `TMR_CFG_OFF) begin
                    cfg <= 2'(merge({30'h0, cfg}, w_data, w_strb));
                end
                if (aw_addr == `TMR_IEN_OFF) begin
                    irq_en <= 4'(merge({28'h0, irq_en}, w_data, w_strb));
                end
                for (int i = 0; i < 2; i++) begin
                    if (aw_addr == `TMR_CTL_OFF + 8'(4*i)) begin
                        ctl[i]    <= `CTL_W'(merge({26'h0, ctl[i]}, w_data, w_strb));
                        reload[i] <= 1'b1;
                    end
                    if (aw_addr == `TMR_LOAD_OFF + 8'(4*i)) begin
                        load[i]   <= 16'(merge({16'h0, load[i]}, w_data, w_strb));
                        reload[i] <= 1'b1;
                    end
                    if (aw_addr == `TMR_MATCH_OFF + 8'(4*i)) begin
                        match[i] <= 16'(merge({16'h0, match[i]}, w_data, w_strb));
                    end
                    if (aw_addr == `TMR_PRE_OFF + 8'(4*i)) begin
                        pre[i] <= 8'(merge({24'h0, pre[i]}, w_data, w_strb));
                    end
                end
                if (aw_addr == `TMR_CFG_OFF) begin
                    reload <= 2'b11;
                end
            end
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 4'h0;
        end else if (do_wr && aw_addr == `TMR_ICLR_OFF && w_strb[0]) begin
            status <= (status & ~w_data[3:0]) | ev_set;
        end else begin
            status <= status | ev_set;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_axi_araddr)
                `TMR_CFG_OFF:             s_axi_rdata <= {30'h0, cfg};
                `TMR_CTL_OFF:             s_axi_rdata <= {26'h0, ctl[0]};
                `TMR_CTL_OFF + 8'h04:     s_axi_rdata <= {26'h0, ctl[1]};
                `TMR_LOAD_OFF:            s_axi_rdata <= {16'h0, load[0]};
                `TMR_LOAD_OFF + 8'h04:    s_axi_rdata <= {16'h0, load[1]};
                `TMR_MATCH_OFF:           s_axi_rdata <= {16'h0, match[0]};
                `TMR_MATCH_OFF + 8'h04:   s_axi_rdata <= {16'h0, match[1]};
                `TMR_PRE_OFF:             s_axi_rdata <= {24'h0, pre[0]};
                `TMR_PRE_OFF + 8'h04:     s_axi_rdata <= {24'h0, pre[1]};
                `TMR_VAL_OFF:             s_axi_rdata <= {16'h0, hb[0].count};
                `TMR_VAL_OFF + 8'h04:     s_axi_rdata <= {16'h0, hb[1].count};
                `TMR_CAP_OFF:             s_axi_rdata <= {16'h0, hb[0].cap_val};
                `TMR_CAP_OFF + 8'h04:     s_axi_rdata <= {16'h0, hb[1].cap_val};
                `TMR_STAT_OFF:            s_axi_rdata <= {28'h0, status};
                `TMR_IEN_OFF:             s_axi_rdata <= {28'h0, irq_en};
                default:                  s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // pins, adc trigger and interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ccp_out     <= 2'b00;
            ccp_oe      <= 2'b00;
            adc_trigger <= 1'b0;
            irq         <= 1'b0;
        end else begin
            ccp_out     <= {hb[1].pwm, hb[0].pwm} & ~{2{concat}};
            ccp_oe      <= {hb[1].oe, hb[0].oe} & ~{2{concat}};
            adc_trigger <= (ev_set[`STAT_TO_BIT] && ctl[0][`CTL_ADC_BIT])
                        || (ev_set[2+`STAT_TO_BIT] && ctl[concat ? 0 : 1][`CTL_ADC_BIT]);
            irq         <= |(status & irq_en);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/timer_half.sv ----
// one 16-bit down-counting timer half with prescaler, capture and pwm
// assumes ev is an already filtered one-cycle pin edge
`default_nettype none
`include "timer_cfg.svh"
module timer_half (
    input wire logic aclk,
    input wire logic aresetn,
    half_if.tmr      h
);
    import timer_pkg::*;

    logic [7:0] pre_cnt;
    logic       tick;
    logic       step;
    logic       oneshot;

    // tick source: external chain, counted events or the clock
    always_comb begin
        if (h.use_tick) begin
            tick = h.tick_in;
        end else if (h.evt_sel && h.mode != MODE_CAPTURE) begin
            tick = h.ev;
        end else begin
            tick = 1'b1;
        end
        step    = h.chain ? tick : (tick && pre_cnt == 8'h00);
        oneshot = h.mode == MODE_ONESHOT;
    end

    // prescaler
    always_ff @(posedge aclk) begin
        if (!aresetn || h.reload) begin
            pre_cnt <= (!aresetn) ? `PRE_RST : h.pre;
        end else if (h.en && tick && !h.chain) begin
            pre_cnt <= (pre_cnt == 8'h00) ? h.pre : pre_cnt - 8'h01;
        end
    end

    // main counter: stop or reload at time-out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h.count   <= `LOAD_RST;
            h.done    <= 1'b0;
            h.timeout <= 1'b0;
        end else begin
            h.timeout <= 1'b0;
            if (h.reload) begin
                h.count <= h.load;
                h.done  <= 1'b0;
            end else if (h.en && step && !h.done) begin
                if (h.count == 16'h0000) begin
                    h.timeout <= 1'b1;
                    if (oneshot) begin
                        h.done <= 1'b1;
                    end else begin
                        h.count <= h.load;
                    end
                end else begin
                    h.count <= h.count - 16'h0001;
                end
            end
        end
    end

    // event capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h.cap_val <= 16'h0000;
            h.cap_evt <= 1'b0;
        end else begin
            h.cap_evt <= h.en && h.mode == MODE_CAPTURE && h.ev;
            if (h.en && h.mode == MODE_CAPTURE && h.ev) begin
                h.cap_val <= h.count;
            end
        end
    end

    // pwm waveform and pin drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h.pwm <= 1'b0;
            h.oe  <= 1'b0;
        end else begin
            h.oe  <= h.mode == MODE_PWM;
            h.pwm <= (h.en && h.mode == MODE_PWM && h.count > h.match) ^ h.invert;
        end
    end
endmodule
`default_nettype wire

// ---- pkg/half_if.sv ----
// control and status between the timer top and one 16-bit half
// assumes the top drives ctl and the half drives tmr
`default_nettype none
interface half_if;
    import timer_pkg::*;
    logic        en;
    mode_e       mode;
    logic        evt_sel;
    logic        invert;
    logic        chain;
    logic        use_tick;
    logic        tick_in;
    logic        ev;
    logic        reload;
    half_t       load;
    half_t       match;
    logic [7:0]  pre;
    half_t       count;
    half_t       cap_val;
    logic        timeout;
    logic        cap_evt;
    logic        done;
    logic        pwm;
    logic        oe;
    modport ctl (output en, mode, evt_sel, invert, chain, use_tick, tick_in, ev, reload, load, match, pre,
                 input count, cap_val, timeout, cap_evt, done, pwm, oe);
    modport tmr (input en, mode, evt_sel, invert, chain, use_tick, tick_in, ev, reload, load, match, pre,
                 output count, cap_val, timeout, cap_evt, done, pwm, oe);
endinterface
`default_nettype wire

// ---- pkg/timer_cfg.svh ----
// register offsets, field positions and reset values of the timer block
// assumes byte addresses on a 32-bit AXI4-Lite register bus
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define TMR_ADDR_W      8
`define TMR_CFG_OFF     8'h00
`define TMR_CTL_OFF     8'h04
`define TMR_LOAD_OFF    8'h0C
`define TMR_MATCH_OFF   8'h14
`define TMR_PRE_OFF     8'h1C
`define TMR_VAL_OFF     8'h24
`define TMR_CAP_OFF     8'h2C
`define TMR_STAT_OFF    8'h34
`define TMR_IEN_OFF     8'h38
`define TMR_ICLR_OFF    8'h3C

`define CFG_CONCAT_BIT  0
`define CFG_RTC_BIT     1
`define CTL_EN_BIT      0
`define CTL_MODE_LSB    1
`define CTL_EVT_BIT     3
`define CTL_INV_BIT     4
`define CTL_ADC_BIT     5
`define CTL_W           6

`define STAT_TO_BIT     0
`define STAT_CAP_BIT    1

`define LOAD_RST        16'hFFFF
`define MATCH_RST       16'h0000
`define PRE_RST         8'h00
`define CTL_RST         6'h00
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ---- pkg/timer_pkg.sv ----
// types shared by the timer block and its interface
// assumes the cfg header is compiled alongside
`default_nettype none
package timer_pkg;
    typedef logic [31:0] word_t;
    typedef logic [15:0] half_t;
    typedef logic [7:0]  addr_t;
    typedef enum logic [1:0] {
        MODE_ONESHOT  = 2'b00,
        MODE_PERIODIC = 2'b01,
        MODE_CAPTURE  = 2'b10,
        MODE_PWM      = 2'b11
    } mode_e;
endpackage
`default_nettype wire

// ---- verification/event_source.sv ----
// far side model: pulses on timer pins and adc trigger counter
// assumes pulses are requested by the bench through pulse()
`default_nettype none
module event_source (
    input  wire logic       aclk,
    input  wire logic       adc_trigger,
    output var  logic [1:0] ccp_in,
    output var  logic       rtc_in,
    output var  int         adc_cnt,
    output var  int         adc_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] pins = 3'h0;
    int         since = 0;
    assign ccp_in = pins[1:0];
    assign rtc_in = pins[2];
    initial adc_cnt = 0;
    // one clean rising edge, held past the input filter
    task automatic pulse(input int k);
        @(posedge aclk);
        pins[k] <= 1'b1;
        repeat (6) @(posedge aclk);
        pins[k] <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
    // adc side: pulse count and spacing
    always @(posedge aclk) begin
        if (adc_trigger === 1'b1) begin
            adc_cnt <= adc_cnt + 1;
            adc_gap <= since;
            since   <= 1;
        end else begin
            since <= since + 1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench of the timer block over AXI4-Lite
// assumes event_source and timer_monitor are compiled first
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import timer_pkg::*;
    logic       aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic       s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rtc_in, adc_trigger, irq;
    addr_t      s_axi_awaddr, s_axi_araddr;
    word_t      s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, ccp_in, ccp_out, ccp_oe, r;
    int         error_cnt = 0, total_checks = 0, adc_cnt, adc_gap, n, a;
    general_timer_module uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ccp_in,
        .ccp_out, .ccp_oe, .rtc_in, .adc_trigger, .irq);
    event_source src (.aclk, .adc_trigger, .ccp_in, .rtc_in, .adc_cnt, .adc_gap);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task chk(input word_t g, input word_t e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input addr_t ad, input word_t v);
        logic aw, w;
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw = 1'b1;
        w  = 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input addr_t ad, output word_t v, output logic [1:0] rr);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        v  = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rc(input addr_t ad, input word_t e);
        rd(ad, d, r);
        chk(d, e);
    endtask
    task hi_count(output int c);
        repeat (10) @(posedge aclk);
        c = 0;
        repeat (20) begin
            @(posedge aclk);
            c += int'(ccp_out[0] === 1'b1);
        end
    endtask
    task t_reset;
        rc(8'h0C, 32'h0000FFFF);
        rc(8'h04, 32'h0);
        rd(8'h42, d, r);
        chk(word_t'(r), 32'h2);
        wr(8'h40, 32'h1);
        chk(word_t'(r), 32'h2);
        chk(word_t'(irq), 32'h0);
    endtask
    task t_oneshot;
        wr(8'h0C, 32'h5);
        chk(word_t'(r), 32'h0);
        wr(8'h04, 32'h21);
        repeat (20) @(posedge aclk);
        rc(8'h24, 32'h0);
        rc(8'h34, 32'h1);
        chk(word_t'(adc_cnt), 32'h1);
        wr(8'h38, 32'h1);
        repeat (3) @(posedge aclk);
        chk(word_t'(irq), 32'h1);
        wr(8'h3C, 32'h1);
        repeat (3) @(posedge aclk);
        chk(word_t'(irq), 32'h0);
        wr(8'h04, 32'h0);
    endtask
    task t_periodic;
        wr(8'h10, 32'h3);
        wr(8'h20, 32'h1);
        wr(8'h08, 32'h23);
        repeat (40) @(posedge aclk);
        chk(word_t'(adc_gap), 32'h8);
        rc(8'h34, 32'h4);
        wr(8'h08, 32'h0);
        wr(8'h3C, 32'hF);
    endtask
    task t_event;
        wr(8'h0C, 32'hFFFF);
        wr(8'h10, 32'hFFFF);
        wr(8'h04, 32'h0B);
        wr(8'h08, 32'h05);
        repeat (3) src.pulse(0);
        src.pulse(1);
        rc(8'h24, 32'hFFFC);
        rc(8'h34, 32'h8);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h3C, 32'hF);
    endtask
    task t_pwm;
        wr(8'h0C, 32'h9);
        wr(8'h14, 32'h6);
        wr(8'h04, 32'h07);
        hi_count(n);
        chk(word_t'(n), 32'h6);
        chk(word_t'(ccp_oe), 32'h1);
        wr(8'h04, 32'h17);
        hi_count(n);
        chk(word_t'(n), 32'hE);
        wr(8'h04, 32'h0);
        wr(8'h3C, 32'hF);
    endtask
    task t_wide;
        a = adc_cnt;
        wr(8'h0C, 32'h7);
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h21);
        repeat (20) @(posedge aclk);
        rc(8'h34, 32'h4);
        rc(8'h24, 32'h0);
        chk(word_t'(adc_cnt), word_t'(a + 1));
        chk(word_t'(ccp_oe), 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h3C, 32'hF);
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h03);
        repeat (2) src.pulse(2);
        rc(8'h34, 32'h0);
        src.pulse(2);
        rc(8'h34, 32'h4);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata  = 32'h0;
        s_axi_wstrb  = 4'hF;
        aresetn      = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_oneshot;
        t_periodic;
        t_event;
        t_pwm;
        t_wide;
        give_verdict;
    end
    initial begin
        #800us;
        error_cnt++;
        give_verdict;
    end
endmodule
bind general_timer_module timer_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .ccp_out, .ccp_oe, .adc_trigger, .irq);
`default_nettype wire

// ---- verification/timer_monitor.sv ----
// concurrent checks of bus answers, trigger pulse and interrupt level
// assumes binding to general_timer_module, one clock aclk
`default_nettype none
module timer_monitor (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [1:0]       ccp_out,
    input wire logic [1:0]       ccp_oe,
    input wire logic             adc_trigger,
    input wire logic             irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_ADC_PULSE: assert property (adc_trigger |=> !adc_trigger)
        else $error("adc trigger longer than one cycle");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READY_BACK: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write readies not restored");
    AST_AR_BACK: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
        else $error("read ready not restored");
    AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("address taken while busy");
    AST_RESET_QUIET: assert property ($rose(aresetn) |-> !irq && !adc_trigger && ccp_oe == 2'b00)
        else $error("outputs active after reset");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
        || $past(s_axi_bvalid, 3))
        else $error("interrupt fell without a write");
    cover property (adc_trigger);
    cover property ($fell(irq));
    cover property (ccp_oe[0] && ccp_out[0]);
endmodule
`default_nettype wire
